// File: rtl/ssci_pkg.sv
// ssci_pkg: constants, types and helpers of the serial switch command interface.
// assumes a single core clock; pins arrive asynchronous and are synchronised in the top.
package ssci_pkg;
    // register addresses
    localparam logic [6:0] ADDR_SW_DATA = 7'h01;
    localparam logic [6:0] ADDR_ERR_CFG = 7'h02;
    localparam logic [6:0] ADDR_ERR_FLAGS = 7'h03;
    localparam logic [6:0] ADDR_BURST = 7'h05;
    localparam logic [6:0] ADDR_RR_EN = 7'h06;
    localparam logic [6:0] ADDR_RR_CHAN = 7'h07;
    localparam logic [6:0] ADDR_CNV_EDGE = 7'h09;
    localparam logic [6:0] ADDR_SOFT_RST = 7'h0B;
    // reset values
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_ERR_CFG = 8'h06;
    localparam logic [7:0] RST_RR_CHAN = 8'hFF;
    // field positions in the error configuration and error flag registers
    localparam int BIT_CRC = 0;
    localparam int BIT_SCLK = 1;
    localparam int BIT_RW = 2;
    localparam logic [2:0] FLAG_BITS = 3'h7;
    // special patterns
    localparam logic [7:0] ALIGN_BYTE = 8'h25;
    localparam logic [15:0] CLEAR_CMD = 16'h6CA9;
    localparam logic [15:0] DAISY_CMD = 16'h2500;
    localparam logic [7:0] SRST_KEY1 = 8'hA3;
    localparam logic [7:0] SRST_KEY2 = 8'h05;
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_SEED = 8'h00;
    // bit counts within a command word
    localparam logic [4:0] CNT_ZERO = 5'h00;
    localparam logic [4:0] CNT_ONE = 5'h01;
    localparam logic [4:0] ADDR_EDGE = 5'h08;
    localparam logic [4:0] CHECK_EDGE = 5'h09;
    localparam logic [4:0] WORD_LEN = 5'h10;
    localparam logic [4:0] WORD_LEN_CRC = 5'h18;
    localparam logic [4:0] CNT_MAX = 5'h1F;

    typedef enum logic {MODE_ADDR = 1'b0, MODE_DAISY = 1'b1} ssci_mode_t;

    typedef struct packed {
        logic csN;
        logic sclk;
        logic sdi;
    } ssci_pins_t;

    typedef struct packed {
        logic [7:0] swData;
        logic [7:0] errCfg;
        logic [7:0] errFlags;
        logic burstEn;
        logic rrEn;
        logic [7:0] rrChan;
        logic cnvEdge;
    } ssci_regs_t;

    localparam ssci_regs_t REGS_DEFAULT = '{RST_ZERO, RST_ERR_CFG, RST_ZERO, 1'b0, 1'b0,
                                            RST_RR_CHAN, 1'b0};

    // crc-8, msb first, over a 16-bit payload
    function automatic logic [7:0] ssci_crc8(input logic [15:0] data);
        logic [7:0] crc;
        crc = CRC_SEED;
        for (int i = 15; i >= 0; i--) begin
            crc = (crc[7] ^ data[i]) ? ({crc[6:0], 1'b0} ^ CRC_POLY) : {crc[6:0], 1'b0};
        end
        return crc;
    endfunction
endpackage

// File: rtl/ssci_serial_switch_if.sv
// ssci_serial_switch_if: serial command interface of an spi-controlled analog mux.
// assumes csN/sclk/sdi are asynchronous pins and sclk is well below core_clk/8;
// sdo is open drain, the pad pulls it low while sdoOe is high.
`timescale 1ns/1ns
`default_nettype none
module ssci_serial_switch_if
    import ssci_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic csN,
    input wire logic sclk,
    input wire logic sdi,
    output logic sdoOut,
    output logic sdoOe,
    output logic [7:0] switchData,
    output logic daisyMode
);
    typedef struct packed {
        ssci_pins_t sync1;
        ssci_pins_t sync2;
        ssci_pins_t sync3;
        ssci_pins_t filt;
        ssci_mode_t mode;
        ssci_regs_t regs;
        logic [4:0] bitCnt;
        logic [15:0] shiftIn;
        logic [15:0] payload;
        logic [6:0] addr;
        logic isRead;
        logic badAddr;
        logic wordDone;
        logic sawRise;
        logic [7:0] outShift;
        logic sdoBit;
        logic sdoOe;
        logic srstArm;
        logic daisyPend;
        logic [7:0] dcShift;
    } ssci_state_t;

    localparam ssci_state_t STATE_RESET = '{
        sync1: '1, sync2: '1, sync3: '1, filt: '1, mode: MODE_ADDR, regs: REGS_DEFAULT,
        bitCnt: CNT_ZERO, shiftIn: '0, payload: '0, addr: '0, isRead: 1'b0,
        badAddr: 1'b0, wordDone: 1'b0, sawRise: 1'b0, outShift: '1, sdoBit: 1'b1,
        sdoOe: 1'b0, srstArm: 1'b0, daisyPend: 1'b0, dcShift: RST_ZERO};

    ssci_state_t q;
    ssci_state_t next_q;

    // register read mux, write-only and missing addresses read as zero
    function automatic logic [7:0] readReg(input ssci_regs_t r, input logic [6:0] a);
        logic [7:0] v;
        v = RST_ZERO;
        case (a)
            ADDR_SW_DATA: v = r.swData;
            ADDR_ERR_CFG: v = r.errCfg;
            ADDR_ERR_FLAGS: v = r.errFlags;
            ADDR_BURST: v = {7'h00, r.burstEn};
            ADDR_RR_EN: v = {7'h00, r.rrEn};
            ADDR_RR_CHAN: v = r.rrChan;
            ADDR_CNV_EDGE: v = {7'h00, r.cnvEdge};
            default: v = RST_ZERO;
        endcase
        return v;
    endfunction

    // address legality: flags is read-only, soft reset is write-only
    function automatic logic addrOk(input logic [6:0] a, input logic rd);
        logic ok;
        ok = 1'b0;
        case (a)
            ADDR_SW_DATA, ADDR_ERR_CFG, ADDR_BURST, ADDR_RR_EN, ADDR_RR_CHAN,
            ADDR_CNV_EDGE: ok = 1'b1;
            ADDR_ERR_FLAGS: ok = rd;
            ADDR_SOFT_RST: ok = !rd;
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction

    // next-state logic
    always_comb begin
        logic csFall;
        logic csRise;
        logic inFrame;
        logic rise;
        logic fall;
        logic bitIn;
        logic crcOn;
        logic [4:0] wordLen;
        logic [4:0] cnt;
        logic [15:0] word;
        logic [15:0] pl;
        logic crcGood;
        logic exempt;
        logic doWrite;
        logic [7:0] resp;
        logic [7:0] byteOut;
        logic [2:0] setFlags;
        csFall = 1'b0;
        csRise = 1'b0;
        inFrame = 1'b0;
        rise = 1'b0;
        fall = 1'b0;
        bitIn = 1'b0;
        crcOn = q.regs.errCfg[BIT_CRC];
        wordLen = crcOn ? WORD_LEN_CRC : WORD_LEN;
        cnt = CNT_ZERO;
        word = '0;
        pl = '0;
        crcGood = 1'b1;
        exempt = 1'b0;
        doWrite = 1'b0;
        resp = q.isRead ? readReg(q.regs, q.addr) : RST_ZERO;
        byteOut = q.outShift;
        setFlags = 3'h0;
        next_q = q;

        // three-stage synchroniser; a level counts once stages two and three agree
        next_q.sync1 = '{csN, sclk, sdi};
        next_q.sync2 = q.sync1;
        next_q.sync3 = q.sync2;
        for (int i = 0; i < 3; i++) begin
            if (q.sync2[i] == q.sync3[i]) begin
                next_q.filt[i] = q.sync3[i];
            end
        end
        csFall = q.filt.csN & ~next_q.filt.csN;
        csRise = ~q.filt.csN & next_q.filt.csN;
        inFrame = ~q.filt.csN & ~next_q.filt.csN;
        rise = inFrame & ~q.filt.sclk & next_q.filt.sclk;
        fall = inFrame & q.filt.sclk & ~next_q.filt.sclk;
        bitIn = next_q.filt.sdi;
        exempt = !q.isRead && (q.addr == CLEAR_CMD[14:8] || q.addr == DAISY_CMD[14:8]);

        // frame start: counter cleared, alignment byte queued msb first (daisy mode presents the daisy shift msb instead)
        if (csFall) begin
            next_q.bitCnt = CNT_ZERO;
            next_q.wordDone = 1'b0;
            next_q.badAddr = 1'b0;
            next_q.sawRise = 1'b0;
            if (q.mode == MODE_DAISY) begin
                next_q.sdoBit = q.dcShift[7];
            end else begin
                next_q.sdoBit = ALIGN_BYTE[7];
                next_q.outShift = {ALIGN_BYTE[6:0], 1'b1};
            end
        end

        // rising edge: shift in, decode, complete a word
        if (rise) begin
            word = {q.shiftIn[14:0], bitIn};
            next_q.shiftIn = word;
            next_q.sawRise = 1'b1;
            if (q.mode == MODE_DAISY) begin
                next_q.dcShift = {q.dcShift[6:0], bitIn};
            end else begin
                // saturating count, so an overlong frame never aliases back
                cnt = (q.bitCnt == CNT_MAX) ? CNT_MAX : q.bitCnt + CNT_ONE;
                next_q.bitCnt = cnt;
                if (!q.wordDone) begin
                    if (cnt == ADDR_EDGE) begin
                        next_q.isRead = word[7];
                        next_q.addr = word[6:0];
                    end
                    if (cnt == CHECK_EDGE) begin
                        next_q.badAddr = !addrOk(q.addr, q.isRead);
                        if (!addrOk(q.addr, q.isRead) && !exempt) begin
                            setFlags[BIT_RW] = q.regs.errCfg[BIT_RW];
                        end
                    end
                    if (cnt == WORD_LEN) begin
                        next_q.payload = word;
                    end
                    if (cnt == wordLen) begin
                        pl = crcOn ? q.payload : word;
                        crcGood = !crcOn || word[7:0] == ssci_crc8(q.payload);
                        if (!crcGood) begin
                            setFlags[BIT_CRC] = 1'b1;
                        end else if (pl == CLEAR_CMD) begin
                            next_q.regs.errFlags = RST_ZERO;
                        end else if (pl == DAISY_CMD) begin
                            next_q.daisyPend = 1'b1;
                        end else if (exempt && q.badAddr) begin
                            setFlags[BIT_RW] = q.regs.errCfg[BIT_RW];
                        end
                        doWrite = crcGood && !q.isRead && !q.badAddr;
                        if (doWrite) begin
                            case (q.addr)
                                ADDR_SW_DATA: next_q.regs.swData = pl[7:0];
                                ADDR_ERR_CFG: next_q.regs.errCfg = {5'h00, pl[2:0]};
                                ADDR_BURST: next_q.regs.burstEn = pl[0];
                                ADDR_RR_EN: next_q.regs.rrEn = pl[0];
                                ADDR_RR_CHAN: next_q.regs.rrChan = pl[7:0];
                                ADDR_CNV_EDGE: next_q.regs.cnvEdge = pl[0];
                                default: next_q.regs.swData = q.regs.swData;
                            endcase
                        end
                        // soft reset key: two back-to-back commands to its address
                        next_q.srstArm = doWrite && q.addr == ADDR_SOFT_RST
                                         && pl[7:0] == SRST_KEY1;
                        if (doWrite && q.addr == ADDR_SOFT_RST && q.srstArm
                            && pl[7:0] == SRST_KEY2) begin
                            next_q.regs = REGS_DEFAULT;
                        end
                        // burst decided by the value this word leaves behind, so a soft reset
                        // or a burst toggle inside the frame still counts as one whole word
                        if (next_q.regs.burstEn) begin
                            next_q.bitCnt = CNT_ZERO;
                            next_q.badAddr = 1'b0;
                        end else begin
                            next_q.wordDone = 1'b1;
                        end
                    end
                end
            end
        end

        // falling edge after a rising edge: present the next output bit
        if (fall && q.sawRise) begin
            next_q.sawRise = 1'b0;
            if (q.mode == MODE_DAISY) begin
                next_q.sdoBit = q.dcShift[7];
            end else begin
                if (!q.wordDone && q.bitCnt == ADDR_EDGE) begin
                    byteOut = resp;
                end else if (!q.wordDone && crcOn && q.bitCnt == WORD_LEN) begin
                    byteOut = ssci_crc8({ALIGN_BYTE, resp});
                end else if (q.bitCnt == CNT_ZERO) begin
                    byteOut = ALIGN_BYTE;
                end
                next_q.sdoBit = byteOut[7];
                next_q.outShift = {byteOut[6:0], 1'b1};
            end
        end

        // frame end: clock count check, daisy load, daisy entry
        if (csRise) begin
            if (q.mode == MODE_DAISY) begin
                next_q.regs.swData = q.dcShift;
            end else begin
                if (q.regs.burstEn ? q.bitCnt != CNT_ZERO : q.bitCnt != wordLen) begin
                    setFlags[BIT_SCLK] = q.regs.errCfg[BIT_SCLK];
                end
                if (q.daisyPend) begin
                    next_q.mode = MODE_DAISY;
                    next_q.dcShift = RST_ZERO;
                    next_q.daisyPend = 1'b0;
                end
            end
        end

        // flag sets come last so a set in a clearing cycle is never lost
        next_q.regs.errFlags[2:0] = next_q.regs.errFlags[2:0] | (setFlags & FLAG_BITS);
        // open drain: pull low only for a zero bit inside a frame
        next_q.sdoOe = ~next_q.filt.csN & ~next_q.sdoBit;
    end

    // state register; synchronous reset restores every default
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            q <= STATE_RESET;
        end else begin
            q <= next_q;
        end
    end

    // outputs straight from flops; sdo data is always the low level
    assign sdoOut = 1'b0;
    assign sdoOe = q.sdoOe;
    assign switchData = q.regs.swData;
    assign daisyMode = q.mode;
endmodule
`default_nettype wire

// File: sim/ssci_chk_sva.sv
// ssci_chk: concurrent checks on the pins of the serial switch command interface.
// assumes pins change only on core_clk rising edges and sclk half periods of 8 clocks.
`timescale 1ns/1ns
`default_nettype none
module ssci_chk (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic csN,
    input wire logic sclk,
    input wire logic sdi,
    input wire logic sdoOut,
    input wire logic sdoOe,
    input wire logic [7:0] switchData,
    input wire logic daisyMode
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // cycles since the last csN or sclk edge; outputs may only move shortly after such an edge
    logic [3:0] quietCnt;
    logic csPrev;
    logic sclkPrev;
    always_ff @(posedge core_clk) begin
        csPrev <= csN;
        sclkPrev <= sclk;
        if (!reset_n || csN != csPrev || sclk != sclkPrev) begin
            quietCnt <= 4'h0;
        end else if (quietCnt != 4'hF) begin
            quietCnt <= quietCnt + 4'h1;
        end
    end
    // eight cycles deselected covers the three-flop synchroniser plus one register
    sequence csIdle;
        csN [*8];
    endsequence
    sequence csStart;
        !daisyMode ##0 $fell(csN);
    endsequence
    chk_sdo_pull_only: assert property (sdoOut == 1'b0)
        else $error("sdo data level not low");
    chk_release_idle: assert property (csIdle |-> !sdoOe)
        else $error("sdo pulled while deselected");
    chk_align_first: assert property (csStart |-> ##[1:8] sdoOe)
        else $error("first alignment bit not low");
    chk_mode_sticky: assert property (daisyMode |=> daisyMode)
        else $error("daisy mode left without reset");
    chk_daisy_entry: assert property ($rose(daisyMode) |-> csN && $past(csN, 2))
        else $error("daisy mode entered inside a frame");
    chk_daisy_load: assert property (daisyMode && $changed(switchData) |-> csN)
        else $error("daisy switch load while selected");
    chk_switch_quiet: assert property (quietCnt >= 4'hC |=> $stable(switchData))
        else $error("switch data moved without pin activity");
    chk_oe_quiet: assert property (quietCnt >= 4'hC |=> $stable(sdoOe))
        else $error("sdo moved without pin activity");
    chk_reset_state: assert property ($rose(reset_n) |->
        switchData == 8'h00 && !daisyMode && !sdoOe)
        else $error("outputs not at defaults after reset");
endmodule
`default_nettype wire

// File: sim/ssci_host_model.sv
// ssci_host_model: behavioural spi controller in mode 0 facing the switch interface.
// assumes sdo is the resolved open-drain wire, pulled up when nobody pulls it low.
`timescale 1ns/1ns
`default_nettype none
module ssci_host_model #(
    parameter int HALF_CYC = 8,
    parameter int INIT_CYC = 15000
) (
    input wire logic core_clk,
    input wire logic sdo,
    output var logic csN,
    output var logic sclk,
    output var logic sdi
);
    // idle pins: deselected, clock parked low
    initial begin
        csN = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
    end
    // the device initialises after any reset; nothing is sent before it is done
    task automatic init_wait();
        repeat (INIT_CYC) @(posedge core_clk);
    endtask
    // crc-8 poly 0x07 seed zero, msb first over the payload
    function automatic logic [7:0] host_crc(input logic [15:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 15; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
        end
        return c;
    endfunction
    // one frame of n clocks; data changes while sclk is low, sdo taken at each rise
    task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
        rx = 32'h00000000;
        @(posedge core_clk);
        csN <= 1'b0;
        for (int k = n - 1; k >= 0; k--) begin
            sdi <= tx[k];
            repeat (HALF_CYC) @(posedge core_clk);
            sclk <= 1'b1;
            rx = {rx[30:0], sdo};
            repeat (HALF_CYC) @(posedge core_clk);
            sclk <= 1'b0;
        end
        repeat (HALF_CYC) @(posedge core_clk);
        csN <= 1'b1;
        repeat (4 * HALF_CYC) @(posedge core_clk);
    endtask
endmodule
`default_nettype wire

// File: sim/test_serial_switch_command_interface.sv
// test_serial_switch_command_interface: self-checking bench driving frames through the host model.
// assumes the design settles within a few core clocks of each pin edge.
`timescale 1ns/1ns
`default_nettype none
module test_serial_switch_command_interface
    import ssci_pkg::*;
();
    logic core_clk;
    logic reset_n;
    logic csN;
    logic sclk;
    logic sdi;
    logic sdoOut;
    logic sdoOe;
    logic [7:0] switchData;
    logic daisyMode;
    logic crcOn;
    logic [31:0] rxw;
    int errTotal = 0;
    int nCompared = 0;
    // open drain with pull-up: low only while the device pulls
    wire logic sdoWire = sdoOe ? sdoOut : 1'b1;
    ssci_serial_switch_if dut (.core_clk(core_clk), .reset_n(reset_n), .csN(csN), .sclk(sclk),
        .sdi(sdi), .sdoOut(sdoOut), .sdoOe(sdoOe), .switchData(switchData),
        .daisyMode(daisyMode));
    ssci_host_model #(.HALF_CYC(8), .INIT_CYC(15000)) host (.core_clk(core_clk), .sdo(sdoWire),
        .csN(csN), .sclk(sclk), .sdi(sdi));
    // 125 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp) begin
            errTotal++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finalReport();
        if (errTotal == 0 && nCompared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic hwReset();
        reset_n <= 1'b0;
        repeat (8) @(posedge core_clk);
        reset_n <= 1'b1;
        host.init_wait();
    endtask
    // one command word, crc byte appended (optionally corrupted) when checking is on
    task automatic cmd(input logic [15:0] w, input logic badCrc);
        if (crcOn) begin
            host.xfer({8'h00, w, host.host_crc(w) ^ {7'h00, badCrc}}, 24, rxw);
        end else begin
            host.xfer({16'h0000, w}, 16, rxw);
        end
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] d, input string what);
        logic [23:0] exp;
        exp = crcOn ? {ALIGN_BYTE, d, host.host_crc({ALIGN_BYTE, d})} : {8'h00, ALIGN_BYTE, d};
        cmd({1'b1, a, 8'h00}, 1'b0);
        check(what, rxw, {8'h00, exp});
    endtask
    initial begin
        crcOn = 1'b0;
        hwReset();
        check("swReset", switchData, 32'h00000000);
        rd(ADDR_ERR_CFG, RST_ERR_CFG, "errCfg");
        rd(ADDR_ERR_FLAGS, 8'h00, "flags");
        cmd({1'b0, ADDR_SW_DATA, 8'h5A}, 1'b0);
        check("wrResp", rxw, 32'h00002500);
        check("swWrite", switchData, 32'h0000005A);
        host.xfer({20'h00000, 1'b0, ADDR_SW_DATA, 4'hF}, 12, rxw);
        check("swShort", switchData, 32'h0000005A);
        rd(ADDR_ERR_FLAGS, 8'h02, "flagShort");
        cmd(CLEAR_CMD, 1'b0);
        host.xfer({12'h000, 1'b0, ADDR_SW_DATA, 8'h33, 4'h0}, 20, rxw);
        check("swLong", switchData, 32'h00000033);
        rd(ADDR_ERR_FLAGS, 8'h02, "flagLong");
        cmd(CLEAR_CMD, 1'b0);
        rd(ADDR_ERR_FLAGS, 8'h00, "flagClr");
        for (int i = 0; i < 3; i++) begin
            cmd({i == 2, (i == 0) ? 7'h10 : ((i == 1) ? ADDR_ERR_FLAGS : 7'h7F), 8'h03}, 1'b0);
            check("swBadAddr", switchData, 32'h00000033);
            rd(ADDR_ERR_FLAGS, 8'h04, "flagAddr");
            cmd(CLEAR_CMD, 1'b0);
        end
        cmd({1'b0, ADDR_ERR_CFG, 8'h02}, 1'b0);
        cmd({1'b0, 7'h10, 8'h03}, 1'b0);
        rd(ADDR_ERR_FLAGS, 8'h00, "flagMask");
        cmd({1'b0, ADDR_ERR_CFG, 8'h07}, 1'b0);
        crcOn = 1'b1;
        rd(ADDR_ERR_CFG, 8'h07, "crcRead");
        cmd(CLEAR_CMD, 1'b0);
        cmd({1'b0, ADDR_SW_DATA, 8'h11}, 1'b0);
        check("crcGood", switchData, 32'h00000011);
        cmd({1'b0, ADDR_SW_DATA, 8'h22}, 1'b1);
        check("crcBad", switchData, 32'h00000011);
        rd(ADDR_ERR_FLAGS, 8'h01, "flagCrc");
        cmd(CLEAR_CMD, 1'b0);
        rd(ADDR_ERR_FLAGS, 8'h00, "crcClr");
        cmd({1'b0, ADDR_ERR_CFG, 8'h06}, 1'b0);
        crcOn = 1'b0;
        cmd(CLEAR_CMD, 1'b0);
        cmd({1'b0, ADDR_BURST, 8'h01}, 1'b0);
        host.xfer({1'b0, ADDR_SW_DATA, 8'h44, 1'b1, ADDR_SW_DATA, 8'h00}, 32, rxw);
        check("burstResp", rxw, 32'h25002544);
        host.xfer({8'h00, 1'b0, ADDR_SW_DATA, 8'h55, 1'b1, ADDR_SW_DATA}, 24, rxw);
        check("burstWr", switchData, 32'h00000055);
        rd(ADDR_ERR_FLAGS, 8'h02, "flagBurst");
        cmd({1'b0, ADDR_SOFT_RST, SRST_KEY1}, 1'b0);
        cmd({1'b0, ADDR_SOFT_RST, SRST_KEY2}, 1'b0);
        check("softSw", switchData, 32'h00000000);
        host.init_wait();
        rd(ADDR_BURST, 8'h00, "softBurst");
        rd(ADDR_ERR_FLAGS, 8'h00, "softFlags");
        cmd(DAISY_CMD, 1'b0);
        check("daisyFwd", rxw, 32'h00002500);
        check("daisyOn", daisyMode, 32'h00000001);
        host.xfer(32'h0000ABCD, 16, rxw);
        check("daisyOut", rxw, 32'h000000AB);
        check("daisySw", switchData, 32'h000000CD);
        host.xfer(32'h0000003C, 8, rxw);
        check("daisyKeep", rxw, 32'h000000CD);
        check("daisySw2", switchData, 32'h0000003C);
        hwReset();
        check("daisyOff", daisyMode, 32'h00000000);
        check("swOff", switchData, 32'h00000000);
        finalReport();
    end
    // watchdog: three init waits plus about forty frames fit well inside this span
    initial begin
        repeat (95000) @(posedge core_clk);
        errTotal++;
        finalReport();
    end
endmodule
bind ssci_serial_switch_if ssci_chk chk (.core_clk(core_clk), .reset_n(reset_n), .csN(csN),
    .sclk(sclk), .sdi(sdi), .sdoOut(sdoOut), .sdoOe(sdoOe), .switchData(switchData),
    .daisyMode(daisyMode));
`default_nettype wire
